// ### gpc_pkg.sv
`default_nettype none
package gpc_pkg;

   localparam int DW = 16;
   localparam int AW = 8;

   localparam logic [AW-1:0] ADDR_PORT_CFG = 8'h0B;
   localparam logic [AW-1:0] ADDR_PIN2     = 8'h0D;
   localparam logic [AW-1:0] ADDR_PIN3     = 8'h0E;

   localparam int BIT_DIR       = 15;
   localparam int BIT_PULL_HI   = 14;
   localparam int BIT_PULL_LO   = 13;
   localparam int BIT_IRQ_MODE  = 12;
   localparam int BIT_INV       = 10;
   localparam int BIT_LEVEL     = 5;
   localparam int BIT_FN_HI     = 3;
   localparam int BIT_FN_LO     = 0;
   localparam int BIT_PORT_SEL  = 0;

   localparam logic DIR_OUT = 1'b0;
   localparam logic DIR_IN  = 1'b1;

   typedef enum logic [1:0] {
      PULL_NONE = 2'h0,
      PULL_DOWN = 2'h1,
      PULL_UP   = 2'h2,
      PULL_RSVD = 2'h3
   } gpc_pull_t;

   typedef enum logic [3:0] {
      FN_LEVEL_IN   = 4'h0,
      FN_EDGE_IN    = 4'h1,
      FN_CLK_OUT    = 4'h2,
      FN_IRQ_OUT    = 4'h3,
      FN_PEN_DOWN   = 4'h4,
      FN_TOUCH_DONE = 4'h5,
      FN_AUX_DONE   = 4'h6,
      FN_TEMP_FLAG  = 4'h7,
      FN_RSVD8      = 4'h8,
      FN_DMIC_CLK   = 4'h9,
      FN_LEVEL_OUT  = 4'hA,
      FN_REGULATOR_UNDERVOLTAGE_FLAG     = 4'hB
   } gpc_fn_t;

   localparam logic [3:0] FN_RSVD_FIRST = 4'hC;

   localparam logic      RST_DIR       = DIR_IN;
   localparam logic      RST_IRQ_MODE  = 1'b0;
   localparam logic      RST_INV       = 1'b0;
   localparam logic      RST_LEVEL     = 1'b0;
   localparam gpc_fn_t   RST_FN        = FN_LEVEL_IN;
   localparam gpc_pull_t PIN2_RST_PULL = PULL_NONE;
   localparam gpc_pull_t PIN3_RST_PULL = PULL_UP;
   localparam logic      RST_PORT_SEL  = 1'b0;

   typedef struct packed {
      logic      dir;
      gpc_pull_t pull;
      logic      irq_mode;
      logic      inv;
      logic      level;
      gpc_fn_t   fn;
   } gpc_cfg_t;

   typedef struct packed {
      logic clock_out_signal;
      logic irq;
      logic pen_down;
      logic touch_done;
      logic aux_done;
      logic temp_flag;
      logic digital_mic_clock;
      logic regulator_undervoltage_flag;
   } gpc_src_t;

   typedef struct packed {
      logic o;
      logic oe;
      logic pull_up;
      logic pull_dn;
      logic evt;
   } gpc_pad_t;

endpackage
`default_nettype wire

// ### gpc_pin.sv
`timescale 1ns/1ps
`default_nettype none
module gpc_pin
   import gpc_pkg::*;
#(
   parameter gpc_pull_t PULL_RESET = PULL_NONE
) (
   input  wire logic           clk_i,
   input  wire logic           nrst_i,
   input  wire logic           ce_i,
   input  wire logic           en_i,
   input  wire logic           wr_i,
   input  wire logic [DW-1:0]  wdata_i,
   input  wire logic           pin_i,
   input  wire gpc_src_t       src_i,
   output logic      [DW-1:0]  rword_o,
   output gpc_cfg_t            cfg_o,
   output gpc_pad_t            pad_o
);

   typedef struct packed {
      gpc_cfg_t cfg;
      logic     pin_s;
      gpc_pad_t pad;
   } gpc_pin_state_t;

   localparam gpc_pin_state_t RST_STATE = '{
      cfg:   '{RST_DIR, PULL_RESET, RST_IRQ_MODE, RST_INV, RST_LEVEL, RST_FN},
      pin_s: 1'b0,
      pad:   '0
   };

   gpc_pin_state_t state_reg;
   gpc_pin_state_t state_next;

   function automatic logic fn_reserved(input gpc_fn_t f);
      fn_reserved = (f == FN_RSVD8) || (f >= FN_RSVD_FIRST);
   endfunction

   always_comb begin
      logic drv;
      drv = 1'b0;
      state_next = state_reg;
      state_next.pin_s = pin_i;
      if (wr_i) begin
         state_next.cfg.dir      = wdata_i[BIT_DIR];
         state_next.cfg.pull     = gpc_pull_t'(wdata_i[BIT_PULL_HI:BIT_PULL_LO]);
         state_next.cfg.irq_mode = wdata_i[BIT_IRQ_MODE];
         state_next.cfg.inv      = wdata_i[BIT_INV];
         state_next.cfg.level    = wdata_i[BIT_LEVEL];
         state_next.cfg.fn       = gpc_fn_t'(wdata_i[BIT_FN_HI:BIT_FN_LO]);
      end
      case (state_next.cfg.fn)
         FN_CLK_OUT:    drv = src_i.clock_out_signal;
         FN_IRQ_OUT:    drv = src_i.irq;
         FN_PEN_DOWN:   drv = src_i.pen_down;
         FN_TOUCH_DONE: drv = src_i.touch_done;
         FN_AUX_DONE:   drv = src_i.aux_done;
         FN_TEMP_FLAG:  drv = src_i.temp_flag;
         FN_DMIC_CLK:   drv = src_i.digital_mic_clock;
         FN_REGULATOR_UNDERVOLTAGE_FLAG:     drv = src_i.regulator_undervoltage_flag;
         default:       drv = state_next.cfg.level ^ state_next.cfg.inv;
      endcase
      // reserved codes leave the pin undriven; the pull field still applies
      state_next.pad.o  = drv;
      state_next.pad.oe = en_i && (state_next.cfg.dir == DIR_OUT)
                          && !fn_reserved(state_next.cfg.fn);
      state_next.pad.pull_up = en_i && (state_next.cfg.pull == PULL_UP);
      state_next.pad.pull_dn = en_i && (state_next.cfg.pull == PULL_DOWN);
      state_next.pad.evt = 1'b0;
      if (en_i && (state_reg.cfg.fn == FN_EDGE_IN)) begin
         if (state_reg.cfg.irq_mode) begin
            state_next.pad.evt = pin_i != state_reg.pin_s;
         end else begin
            state_next.pad.evt = (pin_i ^ state_reg.cfg.inv)
                                 && !(state_reg.pin_s ^ state_reg.cfg.inv);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_reg <= RST_STATE;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   always_comb begin
      rword_o = '0;
      rword_o[BIT_DIR]                 = state_reg.cfg.dir;
      rword_o[BIT_PULL_HI:BIT_PULL_LO] = state_reg.cfg.pull;
      rword_o[BIT_IRQ_MODE]            = state_reg.cfg.irq_mode;
      rword_o[BIT_INV]                 = state_reg.cfg.inv;
      // software sees the pin, not what it last wrote
      rword_o[BIT_LEVEL]               = state_reg.pin_s ^ state_reg.cfg.inv;
      rword_o[BIT_FN_HI:BIT_FN_LO]     = state_reg.cfg.fn;
   end

   assign cfg_o = state_reg.cfg;
   assign pad_o = state_reg.pad;

endmodule
`default_nettype wire

// ### gpc_ctrl_top.sv
// Operation
// - Bit 15 picks direction (0 output, 1 input, reset input) and in output mode with function code 0000, 0001 or 1010 bit 5 drives the pin.
// - Reading the level bit returns the sampled pin level rather than the last written value.
// - With the polarity bit 10 set the held level is the inverse of the pin both ways; reset is non-inverted.
// - Pull field 14:13 gives 00 none, 01 pull-down, 10 pull-up, 11 reserved, and pin 2 resets to none.
// - Pin 3's pull field resets to pull-up.
// - With mode bit 12 set the pin event fires on both pin edges; the bit resets to 0.
// - With mode bit 12 clear the event fires on a single rising edge of the polarity-adjusted level.
// - Function field 3:0 resets to plain level input, and code 0001 makes the pin an edge-detect input.
// - Codes 0010, 0011 and 1010 route the clock output, interrupt request and software level to the pin.
// - Codes 0100 to 0111 route pen-down, touch done, auxiliary done and temperature flag to the pin.
// - Code 1001 routes the microphone clock and code 1011 the regulator undervoltage flag.
// - Pin 3 works as a general pin only once its mode bit is set, and that bit then stays set until reset.
`timescale 1ns/1ps
`default_nettype none
module gpc_ctrl_top
   import gpc_pkg::*;
(
   input  wire logic           CORE_CLK_I,
   input  wire logic           NRST_I,
   input  wire logic           CE_I,
   input  wire logic [AW-1:0]  REG_ADDR_I,
   input  wire logic           REG_WR_I,
   input  wire logic           REG_RD_I,
   input  wire logic [DW-1:0]  REG_WDATA_I,
   output logic      [DW-1:0]  REG_RDATA_O,
   input  wire gpc_src_t       STATUS_I,
   input  wire logic           PIN2_I,
   input  wire logic           PIN3_I,
   output gpc_pad_t            PIN2_PAD_O,
   output gpc_pad_t            PIN3_PAD_O,
   output logic                PIN3_GPIO_MODE_O
);

   localparam int NUM_PINS = 2;

   typedef struct packed {
      logic          port_sel;
      logic [DW-1:0] rdata;
   } gpc_top_state_t;

   localparam gpc_top_state_t RST_TOP = '{port_sel: RST_PORT_SEL, rdata: '0};

   gpc_top_state_t state_reg;
   gpc_top_state_t state_next;

   logic     [NUM_PINS-1:0] wr;
   logic     [NUM_PINS-1:0] en;
   logic     [NUM_PINS-1:0] pin_in;
   logic     [DW-1:0]       rword [NUM_PINS];
   gpc_cfg_t                cfg   [NUM_PINS];
   gpc_pad_t                pad   [NUM_PINS];

   assign pin_in = {PIN3_I, PIN2_I};
   assign en     = {state_reg.port_sel, 1'b1};
   assign wr[0]  = REG_WR_I && (REG_ADDR_I == ADDR_PIN2);
   assign wr[1]  = REG_WR_I && (REG_ADDR_I == ADDR_PIN3);

   generate
      for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
         localparam gpc_pull_t PULL_RST = gpc_pull_t'((g == 0) ? PIN2_RST_PULL : PIN3_RST_PULL);
         gpc_pin #(
            .PULL_RESET (PULL_RST)
         ) u_pin (
            .clk_i   (CORE_CLK_I),
            .nrst_i  (NRST_I),
            .ce_i    (CE_I),
            .en_i    (en[g]),
            .wr_i    (wr[g]),
            .wdata_i (REG_WDATA_I),
            .pin_i   (pin_in[g]),
            .src_i   (STATUS_I),
            .rword_o (rword[g]),
            .cfg_o   (cfg[g]),
            .pad_o   (pad[g])
         );
      end
   endgenerate

   always_comb begin
      state_next = state_reg;
      // only a reset clears the pin 3 mode; writing 0 has no effect
      if (REG_WR_I && (REG_ADDR_I == ADDR_PORT_CFG) && REG_WDATA_I[BIT_PORT_SEL]) begin
         state_next.port_sel = 1'b1;
      end
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            ADDR_PORT_CFG: begin
               state_next.rdata = '0;
               state_next.rdata[BIT_PORT_SEL] = state_reg.port_sel;
            end
            ADDR_PIN2: state_next.rdata = rword[0];
            ADDR_PIN3: state_next.rdata = rword[1];
            default:   state_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         state_reg <= RST_TOP;
      end else if (CE_I) begin
         state_reg <= state_next;
      end
   end

   assign REG_RDATA_O      = state_reg.rdata;
   assign PIN2_PAD_O       = pad[0];
   assign PIN3_PAD_O       = pad[1];
   assign PIN3_GPIO_MODE_O = state_reg.port_sel;

   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!NRST_I);

   sequence s_wr2_drive(logic inv);
      CE_I && wr[0] && (REG_WDATA_I[BIT_DIR] == DIR_OUT)
      && (REG_WDATA_I[BIT_FN_HI:BIT_FN_LO] == FN_LEVEL_OUT) && (REG_WDATA_I[BIT_INV] == inv);
   endsequence

   sequence s_edge_cfg(logic mode);
      CE_I && $past(CE_I) && (cfg[0].fn == FN_EDGE_IN) && (cfg[0].irq_mode == mode);
   endsequence

   sequence s_route(gpc_fn_t f);
      CE_I && !wr[0] && (cfg[0].dir == DIR_OUT) && (cfg[0].fn == f);
   endsequence

   property p_reset_dir;
      !$past(NRST_I) |-> (cfg[0].dir == DIR_IN) && (cfg[1].dir == DIR_IN);
   endproperty
   a_reset_dir: assert property (p_reset_dir) else $error("pin not input after reset");

   property p_reset_pull;
      !$past(NRST_I) |-> (cfg[0].pull == PULL_NONE) && (cfg[1].pull == PULL_UP) && !PIN3_GPIO_MODE_O;
   endproperty
   a_reset_pull: assert property (p_reset_pull) else $error("wrong pull after reset");

   property p_reset_misc;
      !$past(NRST_I) |-> !cfg[0].inv && !cfg[0].irq_mode && (cfg[0].fn == FN_LEVEL_IN);
   endproperty
   a_reset_misc: assert property (p_reset_misc) else $error("wrong config after reset");

   property p_drive;
      s_wr2_drive(1'b0) |=> PIN2_PAD_O.oe && (PIN2_PAD_O.o == $past(REG_WDATA_I[BIT_LEVEL]));
   endproperty
   a_drive: assert property (p_drive) else $error("written level not driven");

   property p_drive_inv;
      s_wr2_drive(1'b1) |=> PIN2_PAD_O.oe && (PIN2_PAD_O.o == !$past(REG_WDATA_I[BIT_LEVEL]));
   endproperty
   a_drive_inv: assert property (p_drive_inv) else $error("inverted drive wrong");

   property p_readback;
      CE_I && $past(CE_I) && $past(NRST_I) && REG_RD_I && (REG_ADDR_I == ADDR_PIN2)
      |=> REG_RDATA_O[BIT_LEVEL] == ($past(PIN2_I, 2) ^ $past(cfg[0].inv));
   endproperty
   a_readback: assert property (p_readback) else $error("level read is not pin level");

   property p_both_edges;
      s_edge_cfg(1'b1) ##0 (PIN2_I != $past(PIN2_I)) |=> PIN2_PAD_O.evt;
   endproperty
   a_both_edges: assert property (p_both_edges) else $error("edge missed in both-edge mode");

   property p_rise_only;
      s_edge_cfg(1'b0) |=> PIN2_PAD_O.evt
         == ($past(PIN2_I ^ cfg[0].inv) && !($past(PIN2_I, 2) ^ $past(cfg[0].inv)));
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("single-edge event wrong");

   property p_route_irq;
      s_route(FN_IRQ_OUT) |=> PIN2_PAD_O.oe && (PIN2_PAD_O.o == $past(STATUS_I.irq));
   endproperty
   a_route_irq: assert property (p_route_irq) else $error("interrupt not routed");

   property p_route_pen;
      s_route(FN_PEN_DOWN) |=> PIN2_PAD_O.o == $past(STATUS_I.pen_down);
   endproperty
   a_route_pen: assert property (p_route_pen) else $error("pen-down not routed");

   property p_route_uv;
      s_route(FN_REGULATOR_UNDERVOLTAGE_FLAG) |=> PIN2_PAD_O.o == $past(STATUS_I.regulator_undervoltage_flag);
   endproperty
   a_route_uv: assert property (p_route_uv) else $error("undervoltage not routed");

   property p_route_clk;
      s_route(FN_CLK_OUT) |=> PIN2_PAD_O.o == $past(STATUS_I.clock_out_signal);
   endproperty
   a_route_clk: assert property (p_route_clk) else $error("clock output not routed");

   property p_route_touch;
      s_route(FN_TOUCH_DONE) |=> PIN2_PAD_O.o == $past(STATUS_I.touch_done);
   endproperty
   a_route_touch: assert property (p_route_touch) else $error("touch done not routed");

   property p_route_aux;
      s_route(FN_AUX_DONE) |=> PIN2_PAD_O.o == $past(STATUS_I.aux_done);
   endproperty
   a_route_aux: assert property (p_route_aux) else $error("auxiliary done not routed");

   property p_route_temp;
      s_route(FN_TEMP_FLAG) |=> PIN2_PAD_O.o == $past(STATUS_I.temp_flag);
   endproperty
   a_route_temp: assert property (p_route_temp) else $error("temperature flag not routed");

   property p_route_dmic;
      s_route(FN_DMIC_CLK) |=> PIN2_PAD_O.o == $past(STATUS_I.digital_mic_clock);
   endproperty
   a_route_dmic: assert property (p_route_dmic) else $error("microphone clock not routed");

   // reset still acts while frozen, which the disable clause covers
   property p_ce_freeze;
      !CE_I |=> $stable(REG_RDATA_O) && $stable(PIN2_PAD_O) && $stable(PIN3_PAD_O)
                && $stable(PIN3_GPIO_MODE_O);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");

   property p_reserved;
      CE_I && !wr[0] && (cfg[0].fn == FN_RSVD8) |=> !PIN2_PAD_O.oe;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code drives pin");

   property p_mode_latch;
      $past(NRST_I) && $past(PIN3_GPIO_MODE_O) |-> PIN3_GPIO_MODE_O;
   endproperty
   a_mode_latch: assert property (p_mode_latch) else $error("pin 3 mode cleared");

   property p_pin3_gate;
      CE_I && !PIN3_GPIO_MODE_O |=> !PIN3_PAD_O.oe && !PIN3_PAD_O.evt && !PIN3_PAD_O.pull_up;
   endproperty
   a_pin3_gate: assert property (p_pin3_gate) else $error("pin 3 active before mode set");

endmodule
`default_nettype wire

// ### gpc_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpc_board_model
   import gpc_pkg::*;
(
   input  wire logic     clk_i,
   input  wire gpc_pad_t pad_i,
   input  wire logic     ext_en_i,
   input  wire logic     ext_val_i,
   output logic          pin_o
);
   logic float_reg = 1'b0;

   // an undriven, unpulled wire must not settle to a convenient value
   always @(posedge clk_i) begin
      float_reg <= ~float_reg;
   end

   // the device drive wins over the board driver, then pulls, then nothing
   always_comb begin
      if (pad_i.oe) begin
         pin_o = pad_i.o;
      end else if (ext_en_i) begin
         pin_o = ext_val_i;
      end else if (pad_i.pull_up) begin
         pin_o = 1'b1;
      end else if (pad_i.pull_dn) begin
         pin_o = 1'b0;
      end else begin
         pin_o = float_reg;
      end
   end
endmodule
`default_nettype wire

// ### gpio_pin_control_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_control_regs_tb_top;
   import gpc_pkg::*;
   logic          clk     = 1'b0;
   logic          nrst    = 1'b0;
   logic          ce      = 1'b1;
   logic [AW-1:0] addr    = '0;
   logic          wr      = 1'b0;
   logic          rd      = 1'b0;
   logic [DW-1:0] wdata   = '0;
   logic [DW-1:0] rdata;
   gpc_src_t      status  = '0;
   logic          pin2;
   logic          pin3;
   gpc_pad_t      pad2;
   gpc_pad_t      pad3;
   logic          gmode;
   logic [1:0]    ext_en  = '0;
   logic [1:0]    ext_val = '0;
   int            err_total = 0;
   int            samples_checked = 0;
   logic [3:0]    fn_tab [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB};
   logic [3:0]    rsv_tab [5] = '{4'h8, 4'hC, 4'hD, 4'hE, 4'hF};

   always #10 clk = ~clk;

   gpc_ctrl_top dut (
      .CORE_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .REG_ADDR_I(addr), .REG_WR_I(wr),
      .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .STATUS_I(status),
      .PIN2_I(pin2), .PIN3_I(pin3), .PIN2_PAD_O(pad2), .PIN3_PAD_O(pad3), .PIN3_GPIO_MODE_O(gmode)
   );
   gpc_board_model brd2 (.clk_i(clk), .pad_i(pad2), .ext_en_i(ext_en[0]), .ext_val_i(ext_val[0]), .pin_o(pin2));
   gpc_board_model brd3 (.clk_i(clk), .pad_i(pad3), .ext_en_i(ext_en[1]), .ext_val_i(ext_val[1]), .pin_o(pin3));

   task automatic complete_run();
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // the extra edge lets a pin 3 mode change reach its pad before a check
   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk(rdata & m, e);
   endtask

   task automatic pull_chk(input gpc_pad_t p, input logic [2:0] e);
      chk({13'h0000, p.oe, p.pull_up, p.pull_dn}, {13'h0000, e});
   endtask

   task automatic drv_chk(input gpc_pad_t p, input logic [1:0] e);
      chk({14'h0000, p.oe, p.o}, {14'h0000, e});
   endtask

   // settle first so a config change cannot leak a pulse into the window
   task automatic evt_cnt(input logic v, input int e);
      int c;
      c = 0;
      repeat (3) @(negedge clk);
      ext_val[0] = v;
      repeat (4) begin
         @(negedge clk);
         if (pad2.evt === 1'b1) begin
            c++;
         end
      end
      chk(DW'(c), DW'(e));
   endtask

   initial begin
      #400000;
      err_total++;
      complete_run();
   end

   initial begin
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      rd_chk(ADDR_PIN2, 16'hFFDF, 16'h8000);
      rd_chk(ADDR_PIN3, 16'hFFDF, 16'hC000);
      rd_chk(8'h20, 16'hFFFF, 16'h0000);
      chk({15'h0000, gmode}, 16'h0000);
      pull_chk(pad3, 3'h0);
      // the last code is the reserved one, which must fall back to no pull
      for (int i = 0; i < 4; i++) begin
         wr_reg(ADDR_PIN2, (16'(i) << 13) | 16'h8000);
         pull_chk(pad2, {1'b0, i == 2, i == 1});
      end
      wr_reg(ADDR_PIN2, 16'h002A);
      drv_chk(pad2, 2'h3);
      rd_chk(ADDR_PIN2, 16'h0020, 16'h0020);
      wr_reg(ADDR_PIN2, 16'h042A);
      drv_chk(pad2, 2'h2);
      rd_chk(ADDR_PIN2, 16'h0020, 16'h0020);
      ext_en[0] = 1'b1;
      wr_reg(ADDR_PIN2, 16'h8020);
      rd_chk(ADDR_PIN2, 16'h0020, 16'h0000);
      wr_reg(ADDR_PIN2, 16'h8420);
      rd_chk(ADDR_PIN2, 16'h0020, 16'h0020);
      // one-hot then inverse one-hot proves exactly the named source is routed
      for (int i = 0; i < 8; i++) begin
         wr_reg(ADDR_PIN2, {12'h000, fn_tab[i]});
         status = gpc_src_t'(8'h01 << (7 - i));
         repeat (2) @(negedge clk);
         drv_chk(pad2, 2'h3);
         status = ~gpc_src_t'(8'h01 << (7 - i));
         repeat (2) @(negedge clk);
         drv_chk(pad2, 2'h2);
      end
      for (int i = 0; i < 5; i++) begin
         wr_reg(ADDR_PIN2, {12'h000, rsv_tab[i]});
         chk({15'h0000, pad2.oe}, 16'h0000);
      end
      status = '0;
      wr_reg(ADDR_PIN2, 16'h9001);
      evt_cnt(1'b1, 1);
      evt_cnt(1'b0, 1);
      wr_reg(ADDR_PIN2, 16'h8001);
      evt_cnt(1'b1, 1);
      evt_cnt(1'b0, 0);
      wr_reg(ADDR_PIN2, 16'h8401);
      evt_cnt(1'b1, 0);
      evt_cnt(1'b0, 1);
      // a write offered while frozen must be lost, not deferred
      ce = 1'b0;
      wr_reg(ADDR_PIN2, 16'h002A);
      chk({15'h0000, pad2.oe}, 16'h0000);
      ce = 1'b1;
      rd_chk(ADDR_PIN2, 16'hFFDF, 16'h8401);
      wr_reg(ADDR_PIN3, 16'h002A);
      chk({15'h0000, pad3.oe}, 16'h0000);
      wr_reg(ADDR_PORT_CFG, 16'h0001);
      chk({15'h0000, gmode}, 16'h0001);
      drv_chk(pad3, 2'h3);
      wr_reg(ADDR_PORT_CFG, 16'h0000);
      chk({15'h0000, gmode}, 16'h0001);
      @(negedge clk);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      chk({15'h0000, gmode}, 16'h0000);
      pull_chk(pad3, 3'h0);
      wr_reg(ADDR_PORT_CFG, 16'h0001);
      pull_chk(pad3, 3'h2);
      rd_chk(ADDR_PIN3, 16'hFFDF, 16'hC000);
      complete_run();
   end
endmodule
`default_nettype wire
